//--- core/adsp_defs.svh
// Register offsets, reset values, field positions and timing counts of the DSP path configuration.
`ifndef ADSP_DEFS_SVH
`define ADSP_DEFS_SVH
`define ADSP_REC_OFS    8'h72
`define ADSP_PLAY_OFS   8'h73
`define ADSP_STAT_OFS   8'h7F
`define ADSP_CFG_RST    8'h18
`define ADSP_FILT_POS   6
`define ADSP_HPF_POS    4
`define ADSP_BQ_POS     2
`define ADSP_SOFT_POS   1
`define ADSP_GANG_POS   0
`define ADSP_CLK_NS     10
`define ADSP_STEP_NS    1000
`define ADSP_STEP_CYC   ((`ADSP_STEP_NS + `ADSP_CLK_NS - 1) / `ADSP_CLK_NS)
`define ADSP_VOL_MUTE   8'h00
`define ADSP_VOL_0DB    8'hC9
`define ADSP_VOL_MAX    8'hFF
`define ADSP_CUT_CODE1  8'h02
`define ADSP_CUT_CODE2  8'h19
`define ADSP_CUT_CODE3  8'hC8
`define ADSP_AP_N0      32'h7FFFFFFF
`define ADSP_AP_N1      32'h00000000
`define ADSP_AP_D1      32'h00000000
`endif

//--- core/adsp_path_config.sv
// Record and playback DSP path configuration with soft-stepped digital volume.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "adsp_defs.svh"

module adsp_path_config #(
  parameter int CH        = 4,
  parameter int STEP_CYC  = `ADSP_STEP_CYC
) (
  input  wire logic                 clock,
  input  wire logic                 reset,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output logic [7:0]                reg_rdata,
  input  wire logic [CH-1:0][7:0]   record_volume,
  input  wire logic [CH-1:0][7:0]   playback_volume,
  input  wire logic [CH-1:0]        record_active,
  input  wire logic [CH-1:0]        playback_active,
  input  wire logic                 coef_write,
  input  wire logic                 coef_path,
  input  wire logic [1:0]           coef_index,
  input  wire logic [31:0]          coef_data,
  output adsp_pkg::adsp_cfg_t       record_cfg,
  output adsp_pkg::adsp_cfg_t       playback_cfg,
  output logic [7:0]                record_cutoff,
  output logic [7:0]                playback_cutoff,
  output logic [2:0]                record_biquad_en,
  output logic [2:0]                playback_biquad_en,
  output adsp_pkg::adsp_coef_t      record_coef,
  output adsp_pkg::adsp_coef_t      playback_coef,
  output logic [CH-1:0][7:0]        record_gain,
  output logic [CH-1:0][7:0]        playback_gain
);

  localparam int CW = $clog2(STEP_CYC + 1);
  localparam logic [CW-1:0] STEP_LAST = CW'(STEP_CYC - 1);

  adsp_pkg::adsp_cfg_t        cfg_r [2];
  adsp_pkg::adsp_coef_t       coef_r [2];
  logic [1:0][7:0]            cut_r;
  logic [1:0][2:0]            bq_r;
  logic [1:0][CH-1:0][7:0]    gain_r;
  logic [1:0][CH-1:0][7:0]    tgt;
  logic [1:0][CH-1:0][7:0]    vol_a;
  logic [1:0][CH-1:0]         act_a;
  logic [1:0]                 busy;
  logic [7:0]                 rdata_r;
  logic [CW-1:0]              cnt_r;
  logic                       tick_r;

  // Fixed cutoffs are reported in units of 1e-5 of the sample rate.
  function automatic logic [7:0] cutoff_of(input logic [1:0] code);
    unique case (code)
      2'h1: cutoff_of = `ADSP_CUT_CODE1;
      2'h2: cutoff_of = `ADSP_CUT_CODE2;
      2'h3: cutoff_of = `ADSP_CUT_CODE3;
      2'h0: cutoff_of = 8'h00;
    endcase
  endfunction

  function automatic logic [2:0] bq_mask(input logic [1:0] n);
    unique case (n)
      2'h0: bq_mask = 3'h0;
      2'h1: bq_mask = 3'h1;
      2'h2: bq_mask = 3'h3;
      2'h3: bq_mask = 3'h7;
    endcase
  endfunction

  function automatic logic [7:0] next_gain(input logic [7:0] cur,
                                           input logic [7:0] goal,
                                           input logic       soft_off,
                                           input logic       tick);
    if (soft_off) begin
      next_gain = goal;
    end else if (tick && cur < goal) begin
      next_gain = cur + 8'h01;
    end else if (tick && cur > goal) begin
      next_gain = cur - 8'h01;
    end else begin
      next_gain = cur;
    end
  endfunction

  assign vol_a = {playback_volume, record_volume};
  assign act_a = {playback_active, record_active};

  // Register writes; both paths share one layout.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cfg_r[0] <= adsp_pkg::adsp_cfg_t'(`ADSP_CFG_RST);
      cfg_r[1] <= adsp_pkg::adsp_cfg_t'(`ADSP_CFG_RST);
    end else if (reg_write) begin
      if (reg_addr == `ADSP_REC_OFS) begin
        cfg_r[0] <= adsp_pkg::adsp_cfg_t'(reg_wdata);
      end
      if (reg_addr == `ADSP_PLAY_OFS) begin
        cfg_r[1] <= adsp_pkg::adsp_cfg_t'(reg_wdata);
      end
    end
  end

  // Read data stand one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (reg_read) begin
      if (reg_addr == `ADSP_REC_OFS) begin
        rdata_r <= cfg_r[0];
      end else if (reg_addr == `ADSP_PLAY_OFS) begin
        rdata_r <= cfg_r[1];
      end else if (reg_addr == `ADSP_STAT_OFS) begin
        rdata_r <= {6'h00, busy};
      end else begin
        rdata_r <= 8'h00;
      end
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // Decoded filter settings; code 3 of the response field is passed on untouched.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cut_r <= '0;
      bq_r  <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        cut_r[p] <= cutoff_of(cfg_r[p].highpass_select);
        bq_r[p]  <= bq_mask(cfg_r[p].biquad_count);
      end
    end
  end

  // Custom high-pass coefficients start as all-pass so selecting code 0 is harmless.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int p = 0; p < 2; p++) begin
        coef_r[p] <= {`ADSP_AP_N0, `ADSP_AP_N1, `ADSP_AP_D1};
      end
    end else if (coef_write) begin
      unique case (coef_index)
        2'h0: coef_r[coef_path].n0 <= coef_data;
        2'h1: coef_r[coef_path].n1 <= coef_data;
        2'h2: coef_r[coef_path].d1 <= coef_data;
        2'h3: ;
      endcase
    end
  end

  // Soft-step pacing: one half-decibel code per tick.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (cnt_r == STEP_LAST) begin
      cnt_r  <= '0;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + CW'(1);
      tick_r <= 1'b0;
    end
  end

  // Targets: ganged paths follow channel 0 even when channel 0 is off; idle channels mute.
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      busy[p] = 1'b0;
      for (int c = 0; c < CH; c++) begin
        if (!act_a[p][c]) begin
          tgt[p][c] = `ADSP_VOL_MUTE;
        end else if (cfg_r[p].volume_gang) begin
          tgt[p][c] = vol_a[p][0];
        end else begin
          tgt[p][c] = vol_a[p][c];
        end
        if (gain_r[p][c] != tgt[p][c]) begin
          busy[p] = 1'b1;
        end
      end
    end
  end

  // The applied gain is the 8-bit volume code itself; the multiplier decodes it.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gain_r <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        for (int c = 0; c < CH; c++) begin
          gain_r[p][c] <= next_gain(gain_r[p][c], tgt[p][c],
                                    cfg_r[p].soft_step_off, tick_r);
        end
      end
    end
  end

  assign reg_rdata          = rdata_r;
  assign record_cfg         = cfg_r[0];
  assign playback_cfg       = cfg_r[1];
  assign record_cutoff      = cut_r[0];
  assign playback_cutoff    = cut_r[1];
  assign record_biquad_en   = bq_r[0];
  assign playback_biquad_en = bq_r[1];
  assign record_coef        = coef_r[0];
  assign playback_coef      = coef_r[1];
  assign record_gain        = gain_r[0];
  assign playback_gain      = gain_r[1];

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_rec_wr;
    reg_write && reg_addr == `ADSP_REC_OFS;
  endsequence

  sequence s_play_wr;
    reg_write && reg_addr == `ADSP_PLAY_OFS;
  endsequence

  property p_rec_write;
    s_rec_wr |=> record_cfg == $past(reg_wdata);
  endproperty
  a_rec_write: assert property (p_rec_write) else $error("record config not written");

  property p_play_write;
    s_play_wr |=> playback_cfg == $past(reg_wdata);
  endproperty
  a_play_write: assert property (p_play_write) else $error("playback config not written");

  property p_rec_read;
    reg_read && reg_addr == `ADSP_REC_OFS && !reg_write |=> reg_rdata == $past(record_cfg);
  endproperty
  a_rec_read: assert property (p_rec_read) else $error("record config readback wrong");

  property p_cutoff;
    s_rec_wr ##1 !reg_write |=> record_cutoff == cutoff_of($past(reg_wdata[5:4], 2));
  endproperty
  a_cutoff: assert property (p_cutoff) else $error("fixed cutoff wrong");

  property p_biquad;
    s_play_wr ##1 !reg_write |=> playback_biquad_en == bq_mask($past(reg_wdata[3:2], 2));
  endproperty
  a_biquad: assert property (p_biquad) else $error("biquad enables wrong");

  property p_allpass;
    $fell(reset) ##0 !coef_write |-> record_coef.n0 == `ADSP_AP_N0 && record_coef.d1 == 32'h0;
  endproperty
  a_allpass: assert property (@(posedge clock) p_allpass) else $error("coefficients not all-pass");

  property p_rec_jump;
    record_cfg.soft_step_off |=> record_gain[1] == $past(tgt[0][1]);
  endproperty
  a_rec_jump: assert property (p_rec_jump) else $error("bypassed step did not jump");

  property p_soft_step;
    !playback_cfg.soft_step_off && !$past(playback_cfg.soft_step_off) |->
      (playback_gain[1] - $past(playback_gain[1]) == 8'h00) ||
      (playback_gain[1] - $past(playback_gain[1]) == 8'h01) ||
      ($past(playback_gain[1]) - playback_gain[1] == 8'h01);
  endproperty
  a_soft_step: assert property (p_soft_step) else $error("soft step moved more than one code");

  property p_rec_gang;
    record_cfg.volume_gang && record_active[1] |-> tgt[0][1] == record_volume[0];
  endproperty
  a_rec_gang: assert property (p_rec_gang) else $error("ganged record target wrong");

  property p_rec_own;
    !record_cfg.volume_gang && record_active[1] |-> tgt[0][1] == record_volume[1];
  endproperty
  a_rec_own: assert property (p_rec_own) else $error("own record target wrong");

  property p_play_gang;
    playback_cfg.volume_gang && playback_cfg.soft_step_off && playback_active[1]
      ##1 $stable(playback_cfg) |-> playback_gain[1] == $past(playback_volume[0]);
  endproperty
  a_play_gang: assert property (p_play_gang) else $error("ganged playback gain wrong");

  property p_play_own;
    !playback_cfg.volume_gang && playback_active[1] |-> tgt[1][1] == playback_volume[1];
  endproperty
  a_play_own: assert property (p_play_own) else $error("own playback target wrong");

endmodule

`default_nettype wire

//--- core/adsp_pkg.sv
// Types shared by the DSP path configuration logic.
package adsp_pkg;
  typedef enum logic [1:0] {
    ADSP_RESP_LINEAR   = 2'h0,
    ADSP_RESP_LOW_LAT  = 2'h1,
    ADSP_RESP_ULOW_LAT = 2'h2,
    ADSP_RESP_RSVD     = 2'h3
  } adsp_resp_t;

  typedef struct packed {
    adsp_resp_t filter_response;
    logic [1:0] highpass_select;
    logic [1:0] biquad_count;
    logic       soft_step_off;
    logic       volume_gang;
  } adsp_cfg_t;

  typedef struct packed {
    logic [31:0] n0;
    logic [31:0] n1;
    logic [31:0] d1;
  } adsp_coef_t;
endpackage

//--- sim/adsp_path_config_bench.sv
// Self-checking bench for the record and playback DSP path configuration block.
`timescale 1ns/1ps
`default_nettype none
`include "adsp_defs.svh"

module adsp_path_config_bench;
  localparam int CH   = 4;
  localparam int STEP = 4;
  localparam logic [7:0] CUT_EXP [4] = '{8'h00, `ADSP_CUT_CODE1, `ADSP_CUT_CODE2, `ADSP_CUT_CODE3};
  localparam logic [2:0] BQM_EXP [4] = '{3'h0, 3'h1, 3'h3, 3'h7};

  logic                 clock           = 1'b0;
  logic                 reset           = 1'b1;
  logic [7:0]           reg_addr        = 8'h00;
  logic [7:0]           reg_wdata       = 8'h00;
  logic                 reg_write       = 1'b0;
  logic                 reg_read        = 1'b0;
  logic [7:0]           reg_rdata;
  logic [CH-1:0][7:0]   record_volume   = {8'h40, 8'hFF, 8'h01, 8'hC9};
  logic [CH-1:0][7:0]   playback_volume = {8'h40, 8'hFF, 8'h01, 8'hC9};
  logic [CH-1:0]        record_active   = 4'hE;
  logic [CH-1:0]        playback_active = 4'hE;
  logic                 coef_write      = 1'b0;
  logic                 coef_path       = 1'b0;
  logic [1:0]           coef_index      = 2'h0;
  logic [31:0]          coef_data       = 32'h00000000;
  adsp_pkg::adsp_cfg_t  record_cfg;
  adsp_pkg::adsp_cfg_t  playback_cfg;
  logic [7:0]           record_cutoff;
  logic [7:0]           playback_cutoff;
  logic [2:0]           record_biquad_en;
  logic [2:0]           playback_biquad_en;
  adsp_pkg::adsp_coef_t record_coef;
  adsp_pkg::adsp_coef_t playback_coef;
  logic [CH-1:0][7:0]   record_gain;
  logic [CH-1:0][7:0]   playback_gain;
  int                   error_cnt       = 0;
  int                   total_checks    = 0;

  always #5 clock = ~clock;

  adsp_path_config #(.CH(CH), .STEP_CYC(STEP)) u_adsp_path_config (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .record_volume(record_volume), .playback_volume(playback_volume),
    .record_active(record_active), .playback_active(playback_active),
    .coef_write(coef_write), .coef_path(coef_path), .coef_index(coef_index),
    .coef_data(coef_data), .record_cfg(record_cfg), .playback_cfg(playback_cfg),
    .record_cutoff(record_cutoff), .playback_cutoff(playback_cutoff),
    .record_biquad_en(record_biquad_en), .playback_biquad_en(playback_biquad_en),
    .record_coef(record_coef), .playback_coef(playback_coef),
    .record_gain(record_gain), .playback_gain(playback_gain));

  task automatic chk(input string nm, input logic [95:0] exp, input logic [95:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // Read data are taken in the single cycle after the strobe, where they stand.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic cw(input logic p, input logic [1:0] i, input logic [31:0] d);
    @(posedge clock);
    coef_path  <= p;
    coef_index <= i;
    coef_data  <= d;
    coef_write <= 1'b1;
    @(posedge clock);
    coef_write <= 1'b0;
    #1;
  endtask

  task automatic chk_gain(input logic [CH-1:0][7:0] exp);
    chk("record_gain", 96'(exp), 96'(record_gain));
    chk("playback_gain", 96'(exp), 96'(playback_gain));
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #50000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    logic [7:0] d;
    logic [7:0] v;
    repeat (16) @(posedge clock);
    #1 chk("record_cfg", `ADSP_CFG_RST, record_cfg);
    chk("playback_cfg", `ADSP_CFG_RST, playback_cfg);
    chk("record_coef", {`ADSP_AP_N0, `ADSP_AP_N1, `ADSP_AP_D1}, record_coef);
    chk("playback_coef", {`ADSP_AP_N0, `ADSP_AP_N1, `ADSP_AP_D1}, playback_coef);
    @(posedge clock);
    reset <= 1'b0;
    rd(`ADSP_REC_OFS, d);
    chk("record_read", `ADSP_CFG_RST, d);
    chk("record_cutoff", 8'h02, record_cutoff);
    chk("playback_biquad_en", 3'h3, playback_biquad_en);
    // Response code 3 is never written; software must keep clear of it.
    for (int i = 0; i < 4; i++) begin
      v = {2'(i % 3), 2'(i), 2'(3 - i), 2'b00};
      wr(`ADSP_REC_OFS, v);
      wr(`ADSP_PLAY_OFS, v);
      rd(`ADSP_PLAY_OFS, d);
      chk("playback_read", v, d);
      chk("record_cfg", v, record_cfg);
      chk("record_cutoff", CUT_EXP[i], record_cutoff);
      chk("playback_cutoff", CUT_EXP[i], playback_cutoff);
      chk("record_biquad_en", BQM_EXP[3-i], record_biquad_en);
      chk("playback_biquad_en", BQM_EXP[3-i], playback_biquad_en);
    end
    wr(8'h74, 8'hFF);
    wr(8'h7F, 8'hFF);
    rd(8'h74, d);
    chk("unmapped_read", 8'h00, d);
    chk("record_cfg", v, record_cfg);
    cw(1'b0, 2'h1, 32'h12345678);
    cw(1'b0, 2'h3, 32'hFFFFFFFF);
    chk("record_coef", {`ADSP_AP_N0, 32'h12345678, `ADSP_AP_D1}, record_coef);
    chk("playback_coef", {`ADSP_AP_N0, `ADSP_AP_N1, `ADSP_AP_D1}, playback_coef);
    cw(1'b1, 2'h2, 32'h0000ABCD);
    cw(1'b1, 2'h0, 32'h40000000);
    chk("playback_coef", {32'h40000000, `ADSP_AP_N1, 32'h0000ABCD}, playback_coef);
    wr(`ADSP_REC_OFS, 8'h1B);
    wr(`ADSP_PLAY_OFS, 8'h1B);
    repeat (3) @(posedge clock);
    // Channel 0 is inactive yet still supplies the ganged volume.
    #1 chk_gain({8'hC9, 8'hC9, 8'hC9, 8'h00});
    wr(`ADSP_REC_OFS, 8'h1A);
    wr(`ADSP_PLAY_OFS, 8'h1A);
    repeat (3) @(posedge clock);
    #1 chk_gain({8'h40, 8'hFF, 8'h01, 8'h00});
    wr(`ADSP_REC_OFS, 8'h18);
    wr(`ADSP_PLAY_OFS, 8'h18);
    @(posedge clock);
    record_volume[1]   <= 8'h03;
    playback_volume[1] <= 8'h03;
    @(posedge clock);
    #1 total_checks++;
    if (!(record_gain[1] inside {8'h01, 8'h02}) ||
        !(playback_gain[1] inside {8'h01, 8'h02})) begin
      error_cnt++;
      $display("mismatch gain_step expected 01 or 02 seen %h %h", record_gain[1], playback_gain[1]);
    end
    rd(`ADSP_STAT_OFS, d);
    chk("ramp_status", 8'h03, d);
    repeat (3 * STEP + 4) @(posedge clock);
    #1 chk_gain({8'h40, 8'hFF, 8'h03, 8'h00});
    rd(`ADSP_STAT_OFS, d);
    chk("ramp_status", 8'h00, d);
    print_verdict();
  end
endmodule

`default_nettype wire
